// ---- hw/atapw_cmd_handler.sv ----
// power and pin-mode command handler with apb task file
`timescale 1ns/1ps
module atapw_cmd_handler #(
	parameter int unsigned TICK_CYCLES = atapw_pkg::UNIT_CYCLES
) (
	input wire logic SYS_CLK_IN,
	input wire logic RST_IN,
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [7:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	output logic [31:0] PRDATA_OUT,
	output logic PREADY_OUT,
	output logic PSLVERR_OUT,
	input wire logic PROTECT_OR_POWERDOWN_PIN_N_IN,
	input wire logic NVM_PIN_MODE_IN,
	output logic NVM_WRITE_OUT,
	output logic NVM_DATA_OUT,
	output logic WRITE_PROTECT_OUT,
	output logic INTRQ_OUT,
	output logic MEDIA_START_OUT,
	output logic MEDIA_WRITE_OUT,
	input wire logic MEDIA_DONE_IN,
	input wire atapw_pkg::atapw_media_err_s MEDIA_ERR_IN,
	output logic [1:0] POWER_STATE_OUT
);
	typedef enum logic [1:0] {S_READY, S_EXEC, S_MEDIA} atapw_state_e;
	atapw_state_e state;
	atapw_pkg::atapw_pwr_e pwr;
	logic [7:0] feat, seccnt, secnum, cyllo, cylhi, devhead, cmd, status, errreg, timeout;
	logic busy, autopd_en, pin_mode, nv_loaded, tick, expire, finish, pd_req;
	logic access, wr, mapped, cmd_wr;

	function automatic logic is_read(input logic [7:0] op);
		case (op)
			8'h20, 8'h21, 8'h24, 8'h29, 8'h40, 8'h42, 8'hC4, 8'hC8, 8'hC9, 8'h25: is_read = 1'b1;
			default: is_read = 1'b0;
		endcase
	endfunction : is_read

	function automatic logic is_write(input logic [7:0] op);
		case (op)
			8'h30, 8'h31, 8'h34, 8'h35, 8'h39, 8'h3C, 8'hC5, 8'hCA, 8'hCB: is_write = 1'b1;
			default: is_write = 1'b0;
		endcase
	endfunction : is_write

	function automatic logic is_mapped(input logic [7:0] a);
		case (a)
			atapw_pkg::ADDR_FEAT_ERR, atapw_pkg::ADDR_SECCNT, atapw_pkg::ADDR_SECNUM,
			atapw_pkg::ADDR_CYLLO, atapw_pkg::ADDR_CYLHI, atapw_pkg::ADDR_DEVHEAD,
			atapw_pkg::ADDR_CMD_STAT, atapw_pkg::ADDR_POWER: is_mapped = 1'b1;
			default: is_mapped = 1'b0;
		endcase
	endfunction : is_mapped

	// apb decode, zero wait state
	assign access = PSEL_IN && PENABLE_IN;
	assign mapped = is_mapped(PADDR_IN);
	assign wr = access && PWRITE_IN && mapped && !busy;
	assign cmd_wr = wr && PADDR_IN == atapw_pkg::ADDR_CMD_STAT;
	assign PREADY_OUT = 1'b1;
	assign PSLVERR_OUT = access && !mapped;
	assign busy = state != S_READY;

	always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			PRDATA_OUT <= 32'h0000_0000;
		end else if (PSEL_IN && !PENABLE_IN) begin
			case (PADDR_IN)
				atapw_pkg::ADDR_FEAT_ERR: PRDATA_OUT <= {24'h00_0000, errreg};
				atapw_pkg::ADDR_SECCNT: PRDATA_OUT <= {24'h00_0000, seccnt};
				atapw_pkg::ADDR_SECNUM: PRDATA_OUT <= {24'h00_0000, secnum};
				atapw_pkg::ADDR_CYLLO: PRDATA_OUT <= {24'h00_0000, cyllo};
				atapw_pkg::ADDR_CYLHI: PRDATA_OUT <= {24'h00_0000, cylhi};
				atapw_pkg::ADDR_DEVHEAD: PRDATA_OUT <= {24'h00_0000, devhead};
				atapw_pkg::ADDR_CMD_STAT: PRDATA_OUT <= {24'h00_0000, status};
				atapw_pkg::ADDR_POWER: PRDATA_OUT <= {16'h0000, timeout, 4'h0, autopd_en,
					pin_mode, 2'(pwr)};
				default: PRDATA_OUT <= 32'h0000_0000;
			endcase
		end
	end

	// task file, writable only while not busy
	always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			feat <= 8'h00;
			seccnt <= 8'h00;
			secnum <= 8'h00;
			cyllo <= 8'h00;
			cylhi <= 8'h00;
			devhead <= 8'h00;
			cmd <= 8'h00;
		end else if (wr) begin
			case (PADDR_IN)
				atapw_pkg::ADDR_FEAT_ERR: feat <= PWDATA_IN[7:0];
				atapw_pkg::ADDR_SECCNT: seccnt <= PWDATA_IN[7:0];
				atapw_pkg::ADDR_SECNUM: secnum <= PWDATA_IN[7:0];
				atapw_pkg::ADDR_CYLLO: cyllo <= PWDATA_IN[7:0];
				atapw_pkg::ADDR_CYLHI: cylhi <= PWDATA_IN[7:0];
				atapw_pkg::ADDR_DEVHEAD: devhead <= PWDATA_IN[7:0];
				atapw_pkg::ADDR_CMD_STAT: cmd <= PWDATA_IN[7:0];
				default: cmd <= cmd;
			endcase
		end
	end

	logic key_ok, is_idle, is_sleep;
	assign is_idle = cmd == atapw_pkg::OP_IDLE_A || cmd == atapw_pkg::OP_IDLE_B;
	assign is_sleep = cmd == atapw_pkg::OP_SLEEP_A || cmd == atapw_pkg::OP_SLEEP_B;
	assign key_ok = cylhi == atapw_pkg::KEY_CYLHI && cyllo == atapw_pkg::KEY_CYLLO &&
		secnum == atapw_pkg::KEY_SECNUM && seccnt == atapw_pkg::KEY_SECCNT &&
		(feat == atapw_pkg::FEAT_WP || feat == atapw_pkg::FEAT_PD);
	assign finish = (state == S_EXEC && !is_read(cmd) && !is_write(cmd)) ||
		(state == S_MEDIA && MEDIA_DONE_IN);

	// command sequencer
	always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			state <= S_READY;
			MEDIA_START_OUT <= 1'b0;
			MEDIA_WRITE_OUT <= 1'b0;
		end else begin
			MEDIA_START_OUT <= 1'b0;
			case (state)
				S_READY: if (cmd_wr) state <= S_EXEC;
				S_EXEC: begin
					if (is_read(cmd) || is_write(cmd)) begin
						MEDIA_START_OUT <= 1'b1;
						MEDIA_WRITE_OUT <= is_write(cmd);
						state <= S_MEDIA;
					end else begin
						state <= S_READY;
					end
				end
				S_MEDIA: if (MEDIA_DONE_IN) state <= S_READY;
				default: state <= S_READY;
			endcase
		end
	end

	// error and status posting per command class
	always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			errreg <= 8'h00;
		end else if (cmd_wr) begin
			errreg <= 8'h00;
		end else if (state == S_EXEC && !is_read(cmd) && !is_write(cmd)) begin
			errreg[atapw_pkg::ER_ABRT] <= !(is_idle || is_sleep ||
				(cmd == atapw_pkg::OP_PINMODE && key_ok));
		end else if (state == S_MEDIA && MEDIA_DONE_IN) begin
			errreg[atapw_pkg::ER_ICRC] <= MEDIA_ERR_IN.icrc;
			errreg[atapw_pkg::ER_UNC] <= MEDIA_ERR_IN.unc && !MEDIA_WRITE_OUT;
			errreg[atapw_pkg::ER_IDNF] <= MEDIA_ERR_IN.idnf;
			errreg[atapw_pkg::ER_ABRT] <= MEDIA_ERR_IN.abrt;
			errreg[atapw_pkg::ER_AMNF] <= MEDIA_ERR_IN.amnf;
		end
	end

	logic corr;
	always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			corr <= 1'b0;
		end else if (cmd_wr) begin
			corr <= 1'b0;
		end else if (state == S_MEDIA && MEDIA_DONE_IN) begin
			corr <= MEDIA_ERR_IN.corr && !MEDIA_WRITE_OUT;
		end
	end

	always_comb begin
		status = 8'h00;
		status[atapw_pkg::ST_BSY] = busy;
		status[atapw_pkg::ST_RDY] = !busy;
		status[atapw_pkg::ST_DSC] = !busy;
		status[atapw_pkg::ST_CORR] = !busy && corr;
		status[atapw_pkg::ST_ERR] = !busy && errreg != 8'h00;
	end

	// interrupt: set on completion, cleared by status read or new command
	always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			INTRQ_OUT <= 1'b0;
		end else if (finish) begin
			INTRQ_OUT <= 1'b1;
		end else if (cmd_wr || (access && !PWRITE_IN && PADDR_IN == atapw_pkg::ADDR_CMD_STAT)) begin
			INTRQ_OUT <= 1'b0;
		end
	end

	// auto power-down settings
	always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			timeout <= atapw_pkg::DEFAULT_UNITS;
			autopd_en <= 1'b1;
		end else if (state == S_EXEC && is_idle) begin
			autopd_en <= 1'b1;
			timeout <= (seccnt != 8'h00) ? seccnt : atapw_pkg::IDLE_ZERO_UNITS;
		end
	end

	atapw_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
		.clk_in(SYS_CLK_IN),
		.rst_in(RST_IN),
		.tick_out(tick)
	);

	atapw_pd_timer u_timer (
		.clk_in(SYS_CLK_IN),
		.rst_in(RST_IN),
		.restart_in(finish || cmd_wr),
		.run_in(autopd_en && !busy && pwr != atapw_pkg::PWR_SLEEP),
		.tick_in(tick),
		.timeout_in(timeout),
		.expire_out(expire)
	);

	// power state
	assign pd_req = pin_mode == atapw_pkg::PIN_MODE_PD && !PROTECT_OR_POWERDOWN_PIN_N_IN;
	assign POWER_STATE_OUT = 2'(pwr);
	always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			pwr <= atapw_pkg::PWR_ACTIVE;
		end else if (cmd_wr) begin
			pwr <= atapw_pkg::PWR_ACTIVE;
		end else if (state == S_EXEC && is_idle) begin
			pwr <= atapw_pkg::PWR_IDLE;
		end else if (state == S_EXEC && is_sleep) begin
			pwr <= atapw_pkg::PWR_SLEEP;
		end else if ((expire && autopd_en) || (pd_req && !busy)) begin
			pwr <= atapw_pkg::PWR_SLEEP;
		end
	end

	// pin mode, restored from non-volatile store after reset
	always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			pin_mode <= atapw_pkg::PIN_MODE_WP;
			nv_loaded <= 1'b0;
			NVM_WRITE_OUT <= 1'b0;
			NVM_DATA_OUT <= atapw_pkg::PIN_MODE_WP;
		end else begin
			NVM_WRITE_OUT <= 1'b0;
			if (!nv_loaded) begin
				nv_loaded <= 1'b1;
				pin_mode <= NVM_PIN_MODE_IN;
			end else if (state == S_EXEC && cmd == atapw_pkg::OP_PINMODE && key_ok) begin
				pin_mode <= (feat == atapw_pkg::FEAT_PD) ? atapw_pkg::PIN_MODE_PD :
					atapw_pkg::PIN_MODE_WP;
				NVM_WRITE_OUT <= 1'b1;
				NVM_DATA_OUT <= (feat == atapw_pkg::FEAT_PD);
			end
		end
	end
	assign WRITE_PROTECT_OUT = pin_mode == atapw_pkg::PIN_MODE_WP &&
		!PROTECT_OR_POWERDOWN_PIN_N_IN;

	// checks
	sequence cmd_taken;
		cmd_wr && state == S_READY;
	endsequence
	sequence done_ready;
		!busy && INTRQ_OUT;
	endsequence
	busy_on_cmd_a: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
		cmd_taken |=> busy) else $error("busy not set after command");
	idle_done_a: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
		(cmd_taken and PWDATA_IN[7:0] == atapw_pkg::OP_IDLE_A) |=> ##1 (done_ready and
		pwr == atapw_pkg::PWR_IDLE)) else $error("idle did not complete");
	idle_timeout_a: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
		(state == S_EXEC && is_idle && seccnt != 8'h00) |=> timeout == $past(seccnt))
		else $error("idle timeout not loaded");
	idle_zero_a: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
		(state == S_EXEC && is_idle && seccnt == 8'h00) |=>
		(timeout == atapw_pkg::IDLE_ZERO_UNITS && autopd_en))
		else $error("zero count not three units");
	sleep_done_a: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
		(state == S_EXEC && is_sleep) |=> (done_ready and pwr == atapw_pkg::PWR_SLEEP))
		else $error("sleep did not complete");
	wake_cmd_a: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
		(cmd_taken and pwr == atapw_pkg::PWR_SLEEP) |=> pwr == atapw_pkg::PWR_ACTIVE)
		else $error("no wake on command");
	expire_sleep_a: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
		(expire && autopd_en && !cmd_wr && state == S_READY) |=> pwr == atapw_pkg::PWR_SLEEP)
		else $error("no sleep on expiry");
	bad_key_a: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
		(state == S_EXEC && cmd == atapw_pkg::OP_PINMODE && !key_ok) |=>
		(errreg[atapw_pkg::ER_ABRT] && $stable(pin_mode))) else $error("bad key accepted");
	pin_mode_a: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
		(state == S_EXEC && cmd == atapw_pkg::OP_PINMODE && key_ok && feat == atapw_pkg::FEAT_WP)
		|=> (pin_mode == atapw_pkg::PIN_MODE_WP && NVM_WRITE_OUT)) else $error("wp mode not set");
	write_mask_a: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
		(state == S_MEDIA && MEDIA_DONE_IN && MEDIA_WRITE_OUT) |=>
		(!errreg[atapw_pkg::ER_UNC] && !corr)) else $error("write flagged unc or corr");
	no_early_sleep_a: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
		finish |=> !expire) else $error("timer expired at restart");
	pd_mode_a: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
		(state == S_EXEC && cmd == atapw_pkg::OP_PINMODE && key_ok && feat == atapw_pkg::FEAT_PD)
		|=> (pin_mode == atapw_pkg::PIN_MODE_PD && NVM_WRITE_OUT &&
		NVM_DATA_OUT == atapw_pkg::PIN_MODE_PD)) else $error("pd mode not set");
	pd_pin_a: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
		(pd_req && !busy && !cmd_wr) |=> pwr == atapw_pkg::PWR_SLEEP)
		else $error("pin power-down ignored");
endmodule : atapw_cmd_handler

// ---- hw/atapw_pkg.sv ----
// constants, types and contract of the ata power and pin-mode command handler
//
// Contract
// - Idle command 97h or E3h sets busy, enters idle, clears busy and raises the interrupt.
// - A nonzero idle sector count becomes the power-down timeout in 5 ms units, auto enabled.
// - A zero idle sector count still enables auto power-down with a timeout of three units.
// - Sleep command 99h or E6h sets busy, enters sleep, clears busy and raises the interrupt.
// - Any new command wakes the device from sleep; a host reset may also wake it.
// - The device sleeps on its own when the inactivity timer expires, 15 ms after reset.
// - Pin-mode command 8Bh with feature AAh makes the shared pin a write-protect input.
// - Pin-mode command with feature 55h makes the shared pin a power-down input.
// - Write-protect use of the shared pin is the factory default.
// - Pin-mode key bytes 6Eh, 44h, 72h and 50h must all match or the command is invalid.
// - The pin mode survives power loss and reset and changes only by the pin-mode command.
// - Each command reports only its valid error and status bits; writes never flag UNC or CORR.
package atapw_pkg;
	localparam int CLK_HZ = 100_000_000;
	localparam int UNIT_US = 5_000;
	localparam int UNIT_CYCLES = UNIT_US * (CLK_HZ / 1_000_000);
	localparam int DEFAULT_MS = 15;
	localparam int UNIT_MS = UNIT_US / 1_000;
	localparam logic [7:0] DEFAULT_UNITS = 8'(DEFAULT_MS / UNIT_MS);
	localparam logic [7:0] IDLE_ZERO_UNITS = 8'h03;
	// register byte addresses
	localparam logic [7:0] ADDR_FEAT_ERR = 8'h04;
	localparam logic [7:0] ADDR_SECCNT = 8'h08;
	localparam logic [7:0] ADDR_SECNUM = 8'h0C;
	localparam logic [7:0] ADDR_CYLLO = 8'h10;
	localparam logic [7:0] ADDR_CYLHI = 8'h14;
	localparam logic [7:0] ADDR_DEVHEAD = 8'h18;
	localparam logic [7:0] ADDR_CMD_STAT = 8'h1C;
	localparam logic [7:0] ADDR_POWER = 8'h20;
	// status bits
	localparam int ST_BSY = 7;
	localparam int ST_RDY = 6;
	localparam int ST_DWF = 5;
	localparam int ST_DSC = 4;
	localparam int ST_CORR = 2;
	localparam int ST_ERR = 0;
	// error bits
	localparam int ER_ICRC = 7;
	localparam int ER_UNC = 6;
	localparam int ER_IDNF = 4;
	localparam int ER_ABRT = 2;
	localparam int ER_AMNF = 0;
	// power register fields
	localparam int PW_STATE_LSB = 0;
	localparam int PW_PINMODE = 2;
	localparam int PW_AUTOEN = 3;
	localparam int PW_TIMEOUT_LSB = 8;
	// opcodes and keys
	localparam logic [7:0] OP_IDLE_A = 8'h97;
	localparam logic [7:0] OP_IDLE_B = 8'hE3;
	localparam logic [7:0] OP_SLEEP_A = 8'h99;
	localparam logic [7:0] OP_SLEEP_B = 8'hE6;
	localparam logic [7:0] OP_PINMODE = 8'h8B;
	localparam logic [7:0] FEAT_WP = 8'hAA;
	localparam logic [7:0] FEAT_PD = 8'h55;
	localparam logic [7:0] KEY_CYLHI = 8'h6E;
	localparam logic [7:0] KEY_CYLLO = 8'h44;
	localparam logic [7:0] KEY_SECNUM = 8'h72;
	localparam logic [7:0] KEY_SECCNT = 8'h50;
	localparam logic PIN_MODE_WP = 1'b0;
	localparam logic PIN_MODE_PD = 1'b1;
	typedef enum logic [1:0] {PWR_ACTIVE, PWR_IDLE, PWR_SLEEP} atapw_pwr_e;
	typedef struct packed {
		logic icrc;
		logic unc;
		logic idnf;
		logic abrt;
		logic amnf;
		logic corr;
	} atapw_media_err_s;
endpackage : atapw_pkg

// ---- hw/atapw_tick.sv ----
// divider giving one enable pulse per timer unit
`timescale 1ns/1ps
module atapw_tick #(
	parameter int unsigned TICK_CYCLES = 500_000
) (
	input wire logic clk_in,
	input wire logic rst_in,
	output logic tick_out
);
	logic [31:0] count;
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			count <= 32'h0000_0000;
			tick_out <= 1'b0;
		end else if (count >= 32'(TICK_CYCLES - 1)) begin
			count <= 32'h0000_0000;
			tick_out <= 1'b1;
		end else begin
			count <= count + 32'h0000_0001;
			tick_out <= 1'b0;
		end
	end
endmodule : atapw_tick

// ---- hw/atapw_pd_timer.sv ----
// inactivity timer counting whole units, one expire pulse
`timescale 1ns/1ps
module atapw_pd_timer (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic restart_in,
	input wire logic run_in,
	input wire logic tick_in,
	input wire logic [7:0] timeout_in,
	output logic expire_out
);
	logic [7:0] units;
	logic fired;
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			units <= 8'h00;
			fired <= 1'b0;
			expire_out <= 1'b0;
		end else if (restart_in) begin
			units <= 8'h00;
			fired <= 1'b0;
			expire_out <= 1'b0;
		end else if (run_in && tick_in && !fired) begin
			units <= units + 8'h01;
			fired <= (units + 8'h01) >= timeout_in;
			expire_out <= (units + 8'h01) >= timeout_in;
		end else begin
			expire_out <= 1'b0;
		end
	end
endmodule : atapw_pd_timer

// ---- test/atapw_far_model.sv ----
// media engine and pin-mode store beside the handler
`timescale 1ns/1ps
module atapw_far_model (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic nvm_write_in,
	input wire logic nvm_data_in,
	output logic nvm_mode_out,
	input wire logic start_in,
	input wire atapw_pkg::atapw_media_err_s inj_in,
	output logic done_out,
	output atapw_pkg::atapw_media_err_s err_out
);
	logic [3:0] cnt;
	logic slow;
	initial nvm_mode_out = atapw_pkg::PIN_MODE_WP;
	always @(posedge clk_in) begin
		if (nvm_write_in) begin
			nvm_mode_out <= nvm_data_in;
		end
	end
	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			cnt <= 4'h0;
			slow <= 1'b0;
			done_out <= 1'b0;
		end else begin
			done_out <= (cnt == 4'h1);
			if (start_in) begin
				cnt <= slow ? 4'h9 : 4'h1;
				slow <= ~slow;
			end else if (cnt != 4'h0) begin
				cnt <= cnt - 4'h1;
			end
		end
	end
	// error flags only meaningful with done
	assign err_out = done_out ? inj_in : ~inj_in;
endmodule : atapw_far_model

// ---- test/testbench.sv ----
// self-checking bench for the power and pin-mode command handler
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fails++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module testbench;
	typedef struct packed {
		logic [7:0] op, feat, sc, chi, err;
		logic [15:0] pw, msk;
		atapw_pkg::atapw_media_err_s inj;
	} atapw_row_s;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic pen = 1'b0;
	logic pwr = 1'b0;
	logic pin_n = 1'b1;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata, q;
	logic pready, pslverr, slverr, nvm_mode, nvm_wr, nvm_d, wp, intrq, mstart, mwrite, mdone;
	logic [1:0] pstate;
	logic [7:0] st;
	atapw_pkg::atapw_media_err_s merr;
	atapw_pkg::atapw_media_err_s inj = '0;
	int fails = 0;
	int cmp_count = 0;
	atapw_row_s rows [14];
	atapw_cmd_handler #(.TICK_CYCLES(10)) dut_u (.SYS_CLK_IN(clk), .RST_IN(rst),
		.PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr),
		.PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
		.PROTECT_OR_POWERDOWN_PIN_N_IN(pin_n), .NVM_PIN_MODE_IN(nvm_mode),
		.NVM_WRITE_OUT(nvm_wr), .NVM_DATA_OUT(nvm_d), .WRITE_PROTECT_OUT(wp),
		.INTRQ_OUT(intrq), .MEDIA_START_OUT(mstart), .MEDIA_WRITE_OUT(mwrite),
		.MEDIA_DONE_IN(mdone), .MEDIA_ERR_IN(merr), .POWER_STATE_OUT(pstate));
	atapw_far_model far_u (.clk_in(clk), .rst_in(rst), .nvm_write_in(nvm_wr),
		.nvm_data_in(nvm_d), .nvm_mode_out(nvm_mode), .start_in(mstart), .inj_in(inj),
		.done_out(mdone), .err_out(merr));
	initial begin
		forever #5 clk = ~clk;
	end
	task automatic close_out;
		$display("checks %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : close_out
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		r = prdata;
		slverr = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask : apb
	task automatic cmd(input logic [7:0] op, feat, sc, chi);
		apb(1'b1, atapw_pkg::ADDR_FEAT_ERR, 32'(feat), q);
		apb(1'b1, atapw_pkg::ADDR_SECCNT, 32'(sc), q);
		apb(1'b1, atapw_pkg::ADDR_SECNUM, 32'(atapw_pkg::KEY_SECNUM), q);
		apb(1'b1, atapw_pkg::ADDR_CYLLO, 32'(atapw_pkg::KEY_CYLLO), q);
		apb(1'b1, atapw_pkg::ADDR_CYLHI, 32'(chi), q);
		apb(1'b1, atapw_pkg::ADDR_CMD_STAT, 32'(op), q);
		@(posedge clk);
		for (int i = 0; i < 100 && intrq !== 1'b1; i++) @(posedge clk);
		`CHK(intrq, 1'b1)
	endtask : cmd
	initial begin
		repeat (5000) @(posedge clk);
		fails++;
		close_out();
	end
	initial begin
		rows = '{
			'{8'h97, 8'h00, 8'h00, 8'h00, 8'h00, 16'h0309, 16'hFF0B, 6'h00},
			'{8'hE3, 8'h00, 8'h07, 8'h00, 8'h00, 16'h0709, 16'hFF0B, 6'h00},
			'{8'h99, 8'h00, 8'h00, 8'h00, 8'h00, 16'h0002, 16'h0003, 6'h00},
			'{8'hE6, 8'h00, 8'h00, 8'h00, 8'h00, 16'h0002, 16'h0003, 6'h00},
			'{8'h97, 8'h00, 8'h00, 8'h00, 8'h00, 16'h0309, 16'hFF0B, 6'h00},
			'{8'h8B, 8'h55, 8'h50, 8'h6E, 8'h00, 16'h0004, 16'h0004, 6'h00},
			'{8'h8B, 8'hAA, 8'h50, 8'h6E, 8'h00, 16'h0000, 16'h0004, 6'h00},
			'{8'h8B, 8'h55, 8'h50, 8'h6F, 8'h04, 16'h0000, 16'h0004, 6'h00},
			'{8'h8B, 8'h12, 8'h50, 8'h6E, 8'h04, 16'h0000, 16'h0004, 6'h00},
			'{8'h8B, 8'h55, 8'h51, 8'h6E, 8'h04, 16'h0000, 16'h0004, 6'h00},
			'{8'hFF, 8'h00, 8'h00, 8'h00, 8'h04, 16'h0000, 16'h0000, 6'h00},
			'{8'h20, 8'h00, 8'h01, 8'h00, 8'hD5, 16'h0000, 16'h0000, 6'h3F},
			'{8'h30, 8'h00, 8'h01, 8'h00, 8'h95, 16'h0000, 16'h0000, 6'h3F},
			'{8'h30, 8'h00, 8'h01, 8'h00, 8'h00, 16'h0000, 16'h0000, 6'h00}};
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		repeat (25) @(posedge clk);
		`CHK(pstate === 2'h2, 1'b0)
		repeat (10) @(posedge clk);
		`CHK(pstate, 2'h2)
		apb(1'b0, atapw_pkg::ADDR_POWER, 32'h0000_0000, q);
		`CHK(q[2], atapw_pkg::PIN_MODE_WP)
		`CHK(q[15:8], atapw_pkg::DEFAULT_UNITS)
		foreach (rows[i]) begin
			inj <= rows[i].inj;
			cmd(rows[i].op, rows[i].feat, rows[i].sc, rows[i].chi);
			if (rows[i].op == 8'h20 || rows[i].op == 8'h30)
				`CHK(mwrite, rows[i].op == 8'h30)
			st = (rows[i].err != 8'h00) ? 8'h01 : 8'h00;
			if (rows[i].op == 8'h20) st = 8'h05;
			apb(1'b0, atapw_pkg::ADDR_CMD_STAT, 32'h0000_0000, q);
			`CHK(q[7:0] & 8'h85, st)
			apb(1'b0, atapw_pkg::ADDR_FEAT_ERR, 32'h0000_0000, q);
			`CHK(q[7:0], rows[i].err)
			`CHK(intrq, 1'b0)
			apb(1'b0, atapw_pkg::ADDR_POWER, 32'h0000_0000, q);
			`CHK(q[15:0] & rows[i].msk, rows[i].pw)
		end
		pin_n <= 1'b0;
		repeat (2) @(posedge clk);
		`CHK(wp, 1'b1)
		pin_n <= 1'b1;
		cmd(atapw_pkg::OP_PINMODE, atapw_pkg::FEAT_PD,
			atapw_pkg::KEY_SECCNT, atapw_pkg::KEY_CYLHI);
		pin_n <= 1'b0;
		repeat (4) @(posedge clk);
		`CHK(pstate, 2'h2)
		`CHK(wp, 1'b0)
		pin_n <= 1'b1;
		rst <= 1'b1;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		apb(1'b0, atapw_pkg::ADDR_POWER, 32'h0000_0000, q);
		`CHK(q[2], atapw_pkg::PIN_MODE_PD)
		cmd(atapw_pkg::OP_IDLE_A, 8'h00, 8'h02, 8'h00);
		repeat (16) @(posedge clk);
		`CHK(pstate, 2'h1)
		repeat (19) @(posedge clk);
		`CHK(pstate, 2'h2)
		apb(1'b0, 8'h3C, 32'h0000_0000, q);
		`CHK({slverr, q}, 33'h1_0000_0000)
		close_out();
	end
endmodule : testbench
